// file: verilog/otd_top.sv
// Output transition delay block: settings registers and two delayed outputs.
`timescale 1ns/1ps

module otd_top #(
  parameter int unsigned STEP_CYCLES = otd_pkg::DLY_STEP_CYC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  input  wire logic [otd_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [otd_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [otd_pkg::DATA_W-1:0]  regRdata,
  input  wire logic                        termSrc,
  input  wire logic                        relaySrc,
  input  wire logic                        driveRunning,
  input  wire logic                        tripClearIn,
  input  wire logic                        motorRunReq,
  output logic                             termOut,
  output logic                             relayOut,
  output logic                             motorOut,
  output logic                             offDelayInUse
);

  logic [otd_pkg::DLY_W-1:0]  dlySet_r [otd_pkg::NUM_SET];
  otd_pkg::otd_dly_t          chDly    [otd_pkg::NUM_CH];
  logic [otd_pkg::NUM_CH-1:0] chSrc;
  logic [otd_pkg::NUM_CH-1:0] chOut;
  logic [otd_pkg::NUM_CH-1:0] chPend;
  logic [otd_pkg::NUM_CH-1:0] chTick;
  logic [otd_pkg::NUM_CH-1:0] chRestart;
  logic                       tripPrev_r;
  logic                       tripEdge;
  logic                       motorOut_r;
  logic [otd_pkg::DATA_W-1:0] rdata_r;
  logic [otd_pkg::DATA_W-1:0] rdata_nxt;
  logic [otd_pkg::DATA_W-1:0] status;
  logic                       wrOk;

  // A setting write is taken only when stopped and the value is in range.
  // range check.
  always_comb begin
    wrOk = regWr && !driveRunning
           && (regWdata[otd_pkg::DATA_W-1:otd_pkg::DLY_W] == 22'h00_0000)
           && (regWdata[otd_pkg::DLY_W-1:0] <= otd_pkg::DLY_MAX);
  end

  // Four delay settings, one register per setting, at consecutive words.
  for (genvar i = 0; i < otd_pkg::NUM_SET; i++) begin : g_set
    localparam logic [otd_pkg::ADDR_W-1:0] OFS = otd_pkg::ADDR_W'(4 * i);
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        dlySet_r[i] <= otd_pkg::DLY_RESET;
      end else if (wrOk && regAddr == OFS) begin
        dlySet_r[i] <= regWdata[otd_pkg::DLY_W-1:0];
      end
    end
  end

  // Group the settings per output so each output is configured on its own.
  always_comb begin
    chDly[otd_pkg::CH_TERM].rise  = dlySet_r[otd_pkg::TERM_RISE_IDX];
    chDly[otd_pkg::CH_TERM].fall  = dlySet_r[otd_pkg::TERM_FALL_IDX];
    chDly[otd_pkg::CH_RELAY].rise = dlySet_r[otd_pkg::RELAY_RISE_IDX];
    chDly[otd_pkg::CH_RELAY].fall = dlySet_r[otd_pkg::RELAY_FALL_IDX];
  end

  assign offDelayInUse = (dlySet_r[otd_pkg::TERM_FALL_IDX] != otd_pkg::DLY_RESET)
                         || (dlySet_r[otd_pkg::RELAY_FALL_IDX] != otd_pkg::DLY_RESET);

  // Edge detect on the trip-clear input, taken as synchronous.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tripPrev_r <= 1'b0;
    end else begin
      tripPrev_r <= tripClearIn;
    end
  end

  assign tripEdge = tripClearIn && !tripPrev_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      motorOut_r <= 1'b0;
    end else begin
      motorOut_r <= motorRunReq && !tripClearIn;
    end
  end

  assign motorOut = motorOut_r;

  // Sources in channel order.
  assign chSrc[otd_pkg::CH_TERM]  = termSrc;
  assign chSrc[otd_pkg::CH_RELAY] = relaySrc;

  // One prescaler and one delay channel per output.
  for (genvar c = 0; c < otd_pkg::NUM_CH; c++) begin : g_ch
    otd_tick_gen #(
      .STEP_CYCLES (STEP_CYCLES)
    ) u_tick (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .restart (chRestart[c]),
      .tick    (chTick[c])
    );

    otd_delay_chan u_chan (
      .ref_clk     (ref_clk),
      .resetn      (resetn),
      .srcIn       (chSrc[c]),
      .tripClearIn (tripClearIn),
      .tripEdge    (tripEdge),
      .dly         (chDly[c]),
      .tick        (chTick[c]),
      .restart     (chRestart[c]),
      .outQ        (chOut[c]),
      .pending     (chPend[c])
    );
  end

  assign termOut  = chOut[otd_pkg::CH_TERM];
  assign relayOut = chOut[otd_pkg::CH_RELAY];

  // Status word showing the live state of the block.
  always_comb begin
    status                         = '0;
    status[otd_pkg::ST_TERM_OUT]   = chOut[otd_pkg::CH_TERM];
    status[otd_pkg::ST_RELAY_OUT]  = chOut[otd_pkg::CH_RELAY];
    status[otd_pkg::ST_TERM_PEND]  = chPend[otd_pkg::CH_TERM];
    status[otd_pkg::ST_RELAY_PEND] = chPend[otd_pkg::CH_RELAY];
    status[otd_pkg::ST_OFF_INUSE]  = offDelayInUse;
    status[otd_pkg::ST_RUNNING]    = driveRunning;
    status[otd_pkg::ST_MOTOR_OUT]  = motorOut_r;
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rdata_nxt = '0;
    case (regAddr)
      otd_pkg::TERM_RISE_OFS:  rdata_nxt[otd_pkg::DLY_W-1:0] = dlySet_r[otd_pkg::TERM_RISE_IDX];
      otd_pkg::TERM_FALL_OFS:  rdata_nxt[otd_pkg::DLY_W-1:0] = dlySet_r[otd_pkg::TERM_FALL_IDX];
      otd_pkg::RELAY_RISE_OFS: rdata_nxt[otd_pkg::DLY_W-1:0] = dlySet_r[otd_pkg::RELAY_RISE_IDX];
      otd_pkg::RELAY_FALL_OFS: rdata_nxt[otd_pkg::DLY_W-1:0] = dlySet_r[otd_pkg::RELAY_FALL_IDX];
      otd_pkg::STATUS_OFS:     rdata_nxt = status;
      default:                 rdata_nxt = '0;
    endcase
  end

  // Read data is valid only in the cycle after the read strobe.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else if (regRd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign regRdata = rdata_r;

  // Trip-clear rising while no off delay is configured.
  sequence tripNoDelay;
    $rose(tripClearIn) && !offDelayInUse;
  endsequence

  // Trip-clear rising while the terminal output, which has a fall delay, is lit.
  sequence tripTermHold;
    $rose(tripClearIn) && termOut && (chDly[otd_pkg::CH_TERM].fall != otd_pkg::DLY_RESET);
  endsequence

  // A write during run leaves the setting as it was.
  runLock_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    regWr && driveRunning |=> $stable(dlySet_r[otd_pkg::TERM_RISE_IDX])
      && $stable(dlySet_r[otd_pkg::TERM_FALL_IDX]) && $stable(dlySet_r[otd_pkg::RELAY_RISE_IDX])
      && $stable(dlySet_r[otd_pkg::RELAY_FALL_IDX]))
    else $error("setting changed while running");

  // Settings never exceed 100.0 seconds.
  rangeLimit_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (dlySet_r[otd_pkg::TERM_RISE_IDX] <= otd_pkg::DLY_MAX)
      && (dlySet_r[otd_pkg::TERM_FALL_IDX] <= otd_pkg::DLY_MAX)
      && (dlySet_r[otd_pkg::RELAY_RISE_IDX] <= otd_pkg::DLY_MAX)
      && (dlySet_r[otd_pkg::RELAY_FALL_IDX] <= otd_pkg::DLY_MAX))
    else $error("setting out of range");

  // A legal write to the relay fall offset while stopped is stored in that setting.
  relayFallWr_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    wrOk && regAddr == otd_pkg::RELAY_FALL_OFS
      |=> dlySet_r[otd_pkg::RELAY_FALL_IDX] == $past(regWdata[otd_pkg::DLY_W-1:0]))
    else $error("relay fall setting not written");

  // Without any off delay, trip-clear drops motor and outputs the next cycle.
  tripImmediate_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    tripNoDelay |=> !motorOut && !termOut && !relayOut)
    else $error("outputs not dropped on trip clear");

  // With a terminal fall delay, the output stays lit for at least eight cycles.
  tripHold_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    tripTermHold |=> termOut [*8])
    else $error("terminal output dropped during trip hold");

  // Off-delay use is flagged whenever the terminal fall setting is nonzero.
  offInUse_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (dlySet_r[otd_pkg::TERM_FALL_IDX] != otd_pkg::DLY_RESET) |-> offDelayInUse)
    else $error("off delay use flag wrong");

  // With zero delays and nothing pending, the terminal follows its source.
  zeroPass_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (chDly[otd_pkg::CH_TERM] == '0) && !tripClearIn && !chPend[otd_pkg::CH_TERM]
      |=> termOut == $past(termSrc))
    else $error("zero delay not passed through");

  // A nonzero rise delay keeps the output low in the cycle after the source rises.
  riseDelayed_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(termSrc) && !termOut && !tripClearIn
      && (chDly[otd_pkg::CH_TERM].rise != otd_pkg::DLY_RESET) |=> !termOut)
    else $error("rise delay skipped");

  // Status read returns the state seen at the strobe.
  statusRead_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    regRd && regAddr == otd_pkg::STATUS_OFS |=> regRdata == $past(status))
    else $error("status read wrong");

endmodule

// file: include/otd_pkg.sv
// Shared constants and types for the output transition delay block.
package otd_pkg;

  // Clock period and the delay step of one tenth of a second.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DLY_STEP_NS   = 100_000_000;
  localparam int unsigned DLY_STEP_CYC  = DLY_STEP_NS / CLK_PERIOD_NS;

  // Extra hold time after the trip-clear input rises, in milliseconds and in steps.
  localparam int unsigned TRIP_HOLD_MS    = 1000;
  localparam int unsigned TRIP_HOLD_STEPS = (TRIP_HOLD_MS * 1_000_000) / DLY_STEP_NS;

  // Delay settings are counted in tenths of a second, 0.0 to 100.0 seconds.
  localparam int unsigned DLY_W = 10;
  localparam logic [DLY_W-1:0] DLY_MAX   = 10'h3E8;
  localparam logic [DLY_W-1:0] DLY_RESET = 10'h000;
  localparam logic [DLY_W-1:0] HOLD_CNT  = DLY_W'(TRIP_HOLD_STEPS);

  // Register bus geometry and register byte offsets.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_SET = 4;
  localparam logic [ADDR_W-1:0] TERM_RISE_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] TERM_FALL_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] RELAY_RISE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] RELAY_FALL_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] STATUS_OFS     = 8'h10;

  // Setting indices, in offset order.
  localparam int unsigned TERM_RISE_IDX  = 0;
  localparam int unsigned TERM_FALL_IDX  = 1;
  localparam int unsigned RELAY_RISE_IDX = 2;
  localparam int unsigned RELAY_FALL_IDX = 3;

  // Status register bit positions.
  localparam int unsigned ST_TERM_OUT   = 0;
  localparam int unsigned ST_RELAY_OUT  = 1;
  localparam int unsigned ST_TERM_PEND  = 2;
  localparam int unsigned ST_RELAY_PEND = 3;
  localparam int unsigned ST_OFF_INUSE  = 4;
  localparam int unsigned ST_RUNNING    = 5;
  localparam int unsigned ST_MOTOR_OUT  = 6;

  // Output channel indices.
  localparam int unsigned CH_TERM  = 0;
  localparam int unsigned CH_RELAY = 1;
  localparam int unsigned NUM_CH   = 2;

  // Rise and fall delay of one output, in tenths of a second.
  typedef struct packed {
    logic [DLY_W-1:0] rise;
    logic [DLY_W-1:0] fall;
  } otd_dly_t;

  // Per-channel states.
  typedef enum logic [1:0] {
    CH_IDLE,
    CH_WAIT,
    CH_HOLD
  } otd_chst_t;

endpackage

// file: verilog/otd_tick_gen.sv
// Restartable prescaler that marks each tenth of a second.
`timescale 1ns/1ps
module otd_tick_gen #(
  parameter int unsigned STEP_CYCLES = otd_pkg::DLY_STEP_CYC
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic restart,
  output logic      tick
);

  logic [31:0] cnt_r;

  // Counts clock cycles and wraps after one step; restart realigns the phase.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 32'h0000_0000;
    end else if (restart || cnt_r == STEP_CYCLES - 1) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  // One-cycle tick at the end of each full step.
  assign tick = !restart && (cnt_r == STEP_CYCLES - 1);

  // A restart always yields one full step before the next tick.
  tickSpacing_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    restart |=> (cnt_r == 32'h0000_0000) && !tick)
    else $error("tick too soon after restart");

endmodule

// file: verilog/otd_delay_chan.sv
// One output channel: delays rising and falling transitions of its source.
`timescale 1ns/1ps
module otd_delay_chan (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             srcIn,
  input  wire logic             tripClearIn,
  input  wire logic             tripEdge,
  input  wire otd_pkg::otd_dly_t dly,
  input  wire logic             tick,
  output logic                  restart,
  output logic                  outQ,
  output logic                  pending
);

  otd_pkg::otd_chst_t            st_r;
  logic [otd_pkg::DLY_W-1:0]     cnt_r;
  logic                          out_r;
  logic                          target;
  logic [otd_pkg::DLY_W-1:0]     useDly;
  logic                          holdLoad;
  logic                          waitLoad;

  // Trip-clear forces the wanted level low; the chosen delay follows the direction.
  always_comb begin
    target   = srcIn && !tripClearIn;
    useDly   = target ? dly.rise : dly.fall;
    holdLoad = tripEdge && out_r && (dly.fall != otd_pkg::DLY_RESET);
    waitLoad = (st_r == otd_pkg::CH_IDLE) && (target != out_r)
               && (useDly != otd_pkg::DLY_RESET);
    restart  = holdLoad || waitLoad;
  end

  // Channel state, step counter and output level.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r  <= otd_pkg::CH_IDLE;
      cnt_r <= otd_pkg::DLY_RESET;
      out_r <= 1'b0;
    end else if (holdLoad) begin
      st_r  <= otd_pkg::CH_HOLD;
      cnt_r <= otd_pkg::HOLD_CNT;
    end else if (target == out_r) begin
      st_r <= otd_pkg::CH_IDLE;
    end else begin
      case (st_r)
        otd_pkg::CH_IDLE: begin
          if (useDly == otd_pkg::DLY_RESET) begin
            out_r <= target;
          end else begin
            st_r  <= otd_pkg::CH_WAIT;
            cnt_r <= useDly;
          end
        end
        otd_pkg::CH_WAIT, otd_pkg::CH_HOLD: begin
          if (tick) begin
            if (cnt_r == 10'h001) begin
              out_r <= target;
              st_r  <= otd_pkg::CH_IDLE;
            end else begin
              cnt_r <= cnt_r - 10'h001;
            end
          end
        end
        default: begin
          st_r <= otd_pkg::CH_IDLE;
        end
      endcase
    end
  end

  assign outQ    = out_r;
  assign pending = (st_r != otd_pkg::CH_IDLE);

  // A trip-clear edge on a lit output with a fall delay loads the hold count.
  holdLoad_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    holdLoad |=> (st_r == otd_pkg::CH_HOLD) && (cnt_r == otd_pkg::HOLD_CNT) && out_r)
    else $error("trip hold not loaded");

  // A source returning to the output level drops the pending change.
  cancelPend_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending && (target == out_r) && !holdLoad |=> !pending && (out_r == $past(out_r)))
    else $error("pending transition not cancelled");

  // Each step decrements the count by exactly one.
  stepCount_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    pending && tick && (target != out_r) && !holdLoad && (cnt_r > 10'h001)
      |=> cnt_r == $past(cnt_r) - 10'h001)
    else $error("delay count step wrong");

endmodule

// file: verification/otd_load_model.sv
// Load model: the external device wired to the terminal output and the relay.
`timescale 1ns/1ps
module otd_load_model (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        termOut,
  input  wire logic        relayOut,
  output logic      [15:0] termEdges,
  output logic      [15:0] relayEdges
);
  logic termPrev_r;
  logic relayPrev_r;

  // The load counts every switching of each line, so a glitch on a cancelled change shows up.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      termPrev_r  <= 1'b0;
      relayPrev_r <= 1'b0;
      termEdges   <= 16'h0;
      relayEdges  <= 16'h0;
    end else begin
      termPrev_r  <= termOut;
      relayPrev_r <= relayOut;
      if (termOut != termPrev_r) begin
        termEdges <= termEdges + 16'h1;
      end
      if (relayOut != relayPrev_r) begin
        relayEdges <= relayEdges + 16'h1;
      end
    end
  end
endmodule

// file: verification/tb_output_transition_delay.sv
// Self-checking testbench for the output transition delay block.
`timescale 1ns/1ps
module tb_output_transition_delay;
  localparam int STEP = 4;
  logic                        ref_clk = 1'b0;
  logic                        resetn = 1'b0;
  logic [otd_pkg::ADDR_W-1:0]  regAddr = 8'h0;
  logic [otd_pkg::DATA_W-1:0]  regWdata = 32'h0;
  logic                        regWr = 1'b0;
  logic                        regRd = 1'b0;
  logic [otd_pkg::DATA_W-1:0]  regRdata;
  logic                        termSrc = 1'b0;
  logic                        relaySrc = 1'b0;
  logic                        driveRunning = 1'b0;
  logic                        tripClearIn = 1'b0;
  logic                        motorRunReq = 1'b0;
  logic                        termOut;
  logic                        relayOut;
  logic                        motorOut;
  logic                        offDelayInUse;
  logic [15:0]                 termEdges;
  logic [15:0]                 relayEdges;
  logic [31:0]                 lfsr = 32'hF85CFF4F;
  int                          compares = 0;
  int                          miscompares = 0;

  // The clock toggles every half period of 5 ns.
  always #5 ref_clk = ~ref_clk;

  otd_top #(.STEP_CYCLES(STEP)) i_otd_top (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .termSrc(termSrc),
    .relaySrc(relaySrc), .driveRunning(driveRunning), .tripClearIn(tripClearIn),
    .motorRunReq(motorRunReq), .termOut(termOut), .relayOut(relayOut),
    .motorOut(motorOut), .offDelayInUse(offDelayInUse)
  );

  otd_load_model i_otd_load_model (
    .ref_clk(ref_clk), .resetn(resetn), .termOut(termOut), .relayOut(relayOut),
    .termEdges(termEdges), .relayEdges(relayEdges)
  );

  // Next state of the stimulus shift register.
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Delayed output of the chosen channel.
  function automatic logic outOf(input int ch);
    return (ch == 0) ? termOut : relayOut;
  endfunction

  // Rise setting offset of a channel; the fall setting sits four bytes above.
  function automatic logic [7:0] baseOf(input int ch);
    return (ch == 0) ? otd_pkg::TERM_RISE_OFS : otd_pkg::RELAY_RISE_OFS;
  endfunction

  // Compares a seen value with the expected one and counts the result.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ends the run with the counts and the verdict.
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One register write cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask

  // One register read cycle, compared in the cycle after the strobe.
  task automatic chkRd(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    check(what, regRdata, exp);
  endtask

  // Writes both delay settings of one channel.
  task automatic setDly(input int ch, input logic [31:0] r, input logic [31:0] f);
    wr(baseOf(ch), r);
    wr(baseOf(ch) + 8'h4, f);
  endtask

  // Drives the source of a channel and checks the moment the output follows.
  task automatic edgeChk(input int ch, input logic v, input int d);
    @(posedge ref_clk);
    if (ch == 0) termSrc <= v;
    else relaySrc <= v;
    @(posedge ref_clk);
    // The output moves at edge 1 + d * STEP after the drive edge, so look one edge earlier.
    if (d > 0) begin
      repeat (d * STEP - 1) @(posedge ref_clk);
      #1;
      check("output before expiry", outOf(ch), !v);
      @(posedge ref_clk);
    end
    #1;
    check("output after expiry", outOf(ch), v);
  endtask

  // Cuts a hang short.
  initial begin
    #400000;
    miscompares++;
    summarize();
  end

  initial begin
    logic [1:0] r;
    logic [1:0] f;
    int         ch;
    logic [15:0] edgesBefore;
    logic [15:0] relayBefore;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      chkRd("setting default", 8'(4 * i), 32'h0);
    end
    check("off delay idle", offDelayInUse, 1'b0);
    $display("test defaults done");
    @(posedge ref_clk);
    driveRunning <= 1'b1;
    for (int i = 0; i < 4; i++) wr(8'(4 * i), 32'h5);
    chkRd("status running", otd_pkg::STATUS_OFS, 32'h20);
    @(posedge ref_clk);
    driveRunning <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      chkRd("setting locked", 8'(4 * i), 32'h0);
    end
    wr(otd_pkg::TERM_RISE_OFS, 32'h3E8);
    chkRd("max setting", otd_pkg::TERM_RISE_OFS, 32'h3E8);
    wr(otd_pkg::TERM_RISE_OFS, 32'h3E9);
    chkRd("over range", otd_pkg::TERM_RISE_OFS, 32'h3E8);
    wr(otd_pkg::TERM_RISE_OFS, 32'h10003);
    chkRd("upper bits", otd_pkg::TERM_RISE_OFS, 32'h3E8);
    wr(otd_pkg::TERM_RISE_OFS, 32'h0);
    wr(8'h40, 32'h5);
    chkRd("unmapped", 8'h40, 32'h0);
    wr(otd_pkg::STATUS_OFS, 32'hFF);
    chkRd("status idle", otd_pkg::STATUS_OFS, 32'h0);
    $display("test register access done");
    wr(otd_pkg::RELAY_FALL_OFS, 32'h1);
    check("relay fall in use", offDelayInUse, 1'b1);
    wr(otd_pkg::RELAY_FALL_OFS, 32'h0);
    check("no fall in use", offDelayInUse, 1'b0);
    wr(otd_pkg::TERM_FALL_OFS, 32'h3);
    check("term fall in use", offDelayInUse, 1'b1);
    wr(otd_pkg::TERM_FALL_OFS, 32'h0);
    $display("test off delay flag done");
    for (int c = 0; c < 2; c++) begin
      edgeChk(c, 1'b1, 0);
      edgeChk(c, 1'b0, 0);
    end
    $display("test zero delay done");
    for (int n = 0; n < 12; n++) begin
      lfsr = lfsrNext(lfsr);
      ch = int'(lfsr[0]);
      r = lfsr[2:1];
      f = lfsr[4:3];
      setDly(ch, 32'(r), 32'(f));
      chkRd("random rise", baseOf(ch), 32'(r));
      edgeChk(ch, 1'b1, int'(r));
      edgeChk(ch, 1'b0, int'(f));
    end
    $display("test random delays done");
    setDly(0, 32'h2, 32'h2);
    setDly(1, 32'h2, 32'h2);
    edgesBefore = termEdges;
    relayBefore = relayEdges;
    @(posedge ref_clk);
    termSrc  <= 1'b1;
    relaySrc <= 1'b1;
    // Both channels wait and a fall delay is set: pending bits and off-delay flag.
    chkRd("status pending", otd_pkg::STATUS_OFS, 32'h1C);
    @(posedge ref_clk);
    termSrc  <= 1'b0;
    relaySrc <= 1'b0;
    repeat (3 * STEP + 4) @(posedge ref_clk);
    #1;
    check("cancelled rise", termOut, 1'b0);
    check("no glitch", termEdges, edgesBefore);
    check("relay no glitch", relayEdges, relayBefore);
    $display("test cancel done");
    setDly(0, 32'h0, 32'h0);
    setDly(1, 32'h0, 32'h0);
    @(posedge ref_clk);
    termSrc     <= 1'b1;
    relaySrc    <= 1'b1;
    motorRunReq <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check("outputs on", {motorOut, relayOut, termOut}, 3'h7);
    check("no off delay", offDelayInUse, 1'b0);
    @(posedge ref_clk);
    tripClearIn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("trip drops all", {motorOut, relayOut, termOut}, 3'h0);
    @(posedge ref_clk);
    tripClearIn <= 1'b0;
    setDly(0, 32'h0, 32'h1);
    repeat (3) @(posedge ref_clk);
    #1;
    check("outputs back on", {motorOut, relayOut, termOut}, 3'h7);
    @(posedge ref_clk);
    tripClearIn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("trip with hold", {motorOut, relayOut, termOut}, 3'h1);
    repeat (otd_pkg::TRIP_HOLD_STEPS * STEP - 2) @(posedge ref_clk);
    #1;
    check("term held", termOut, 1'b1);
    @(posedge ref_clk);
    #1;
    check("term released", termOut, 1'b0);
    $display("test trip clear done");
    summarize();
  end
endmodule
